// *** core/sswd_ctl.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Synchronous flow-through SRAM core: load, burst, write and deselect control.
// ----------------------------------------------------------------------------

module sswd_ctl
  import sswd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clock_enable_n_in,
  input wire logic chip_select_low_a_in,
  input wire logic chip_select_low_b_in,
  input wire logic chip_select_high_in,
  input wire logic advance_or_load_in,
  input wire logic read_not_write_in,
  input wire logic burst_order_select_in,
  input wire logic [16:0] addr_in,
  input wire logic [3:0] byte_lane_write_n_in,
  input wire logic [35:0] data_in,
  output logic [35:0] data_out,
  output logic data_oe_out,
  output logic write_queue_ready_out,
  output logic burst_active_out
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [35:0] mem_r [0:SSWD_WORDS-1];
  sswd_state_t state_r;
  sswd_state_t state_nxt;
  logic [16:0] base_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [1:0] low_nxt;
  logic [16:0] burst_addr;
  sswd_op_t pend_r;
  sswd_op_t acc;
  logic enabled;
  logic selected;
  logic load;
  logic op_start;
  logic op_adv;
  logic rd_now;
  logic [35:0] rd_word;
  logic [35:0] data_r;
  logic data_oe_r;
  logic wq_ready_r;
  logic burst_r;
  sswd_wr_t push_word;
  logic push_valid;
  logic push_ready;
  sswd_wr_t drain_word;
  logic [SSWD_WR_W-1:0] drain_bits;
  logic drain_valid;
  logic drain_ready;
  logic [SSWD_WQ_DEPTH*SSWD_WR_W-1:0] view;
  logic [SSWD_WQ_DEPTH-1:0] view_valid;

  // --------------------------------------------------------------------------
  // Pin decode
  // --------------------------------------------------------------------------

  // A suspended edge is treated as if it never happened.
  assign enabled = ~clock_enable_n_in;

  // All three selects active means low, low and high.
  assign selected = ~chip_select_low_a_in & ~chip_select_low_b_in & chip_select_high_in;

  // Advance-or-load low loads a new address and control word.
  assign load = ~advance_or_load_in;

  // A new operation is loaded only while fully selected.
  assign op_start = enabled & selected & load;

  // A burst step needs advance high and a burst in progress.
  assign op_adv = enabled & selected & ~load & (state_r != SSWD_IDLE);

  // --------------------------------------------------------------------------
  // Burst address generation
  // --------------------------------------------------------------------------

  // Only the two lowest bits step; the upper bits hold the loaded base.
  always_comb begin
    cnt_nxt = cnt_r + SSWD_CNT_STEP;
    if (burst_order_select_in) begin
      low_nxt = base_r[1:0] ^ cnt_nxt;
    end else begin
      low_nxt = base_r[1:0] + cnt_nxt;
    end
    burst_addr = {base_r[16:SSWD_BURST_W], low_nxt};
  end

  // --------------------------------------------------------------------------
  // Access selection for this edge
  // --------------------------------------------------------------------------

  // The burst direction comes from the state, not from the live pin.
  always_comb begin
    acc.valid = op_start | op_adv;
    acc.lane_wr_n = byte_lane_write_n_in;
    if (op_start) begin
      acc.write = ~read_not_write_in;
      acc.addr = addr_in;
    end else begin
      acc.write = (state_r == SSWD_WRITE_BURST);
      acc.addr = burst_addr;
    end
  end

  // A read is served from the array at the edge that loads its address.
  assign rd_now = acc.valid & ~acc.write;

  // --------------------------------------------------------------------------
  // Burst state
  // --------------------------------------------------------------------------

  // Any inactive select drops the burst; a load fixes the new direction.
  always_comb begin
    state_nxt = state_r;
    if (!selected) begin
      state_nxt = SSWD_IDLE;
    end else if (load) begin
      if (read_not_write_in) begin
        state_nxt = SSWD_READ_BURST;
      end else begin
        state_nxt = SSWD_WRITE_BURST;
      end
    end
  end

  // State advances on enabled edges only.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= SSWD_IDLE;
    end else if (enabled) begin
      state_r <= state_nxt;
    end
  end

  // Base address and burst count are loaded together; only the count steps on an advance.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      base_r <= SSWD_ADDR_RST;
      cnt_r <= SSWD_CNT_RST;
    end else if (op_start) begin
      base_r <= addr_in;
      cnt_r <= SSWD_CNT_RST;
    end else if (op_adv) begin
      cnt_r <= cnt_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Data phase pipeline
  // --------------------------------------------------------------------------

  // The access taken now has its data phase at the next enabled edge.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_r <= '{valid: 1'b0, write: 1'b0, addr: SSWD_ADDR_RST, lane_wr_n: SSWD_LANES_OFF};
    end else if (enabled) begin
      pend_r <= acc;
    end
  end

  // A pending write captures its data even when a deselect comes with it.
  always_comb begin
    push_valid = enabled & pend_r.valid & pend_r.write;
    push_word.addr = pend_r.addr;
    push_word.data = data_in;
    push_word.lane_wr_n = pend_r.lane_wr_n;
  end

  // --------------------------------------------------------------------------
  // Write queue and array
  // --------------------------------------------------------------------------

  // Array writes wait while a read uses the port or the clock is suspended.
  assign drain_ready = enabled & ~rd_now;
  assign drain_word = sswd_wr_t'(drain_bits);

  sswd_fifo #(
    .WIDTH(SSWD_WR_W),
    .DEPTH(SSWD_WQ_DEPTH)
  ) u_wq (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in(push_word),
    .out_valid_out(drain_valid),
    .out_ready_in(drain_ready),
    .out_data_out(drain_bits),
    .view_out(view),
    .view_valid_out(view_valid)
  );

  // Only lanes whose write enable was low are changed in the array.
  always_ff @(posedge ref_clk_in) begin
    if (drain_valid && drain_ready) begin
      for (int l = 0; l < SSWD_LANES; l++) begin
        if (!drain_word.lane_wr_n[l]) begin
          mem_r[drain_word.addr][l*SSWD_LANE_W +: SSWD_LANE_W] <= drain_word.data[l*SSWD_LANE_W +: SSWD_LANE_W];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read path with forwarding of queued writes
  // --------------------------------------------------------------------------

  // Queued and just-captured writes overlay the array word, oldest first.
  always_comb begin
    sswd_wr_t ent;
    ent = push_word;
    rd_word = mem_r[acc.addr];
    for (int i = 0; i < SSWD_WQ_DEPTH; i++) begin
      ent = sswd_wr_t'(view[i*SSWD_WR_W +: SSWD_WR_W]);
      if (view_valid[i] && (ent.addr == acc.addr)) begin
        for (int l = 0; l < SSWD_LANES; l++) begin
          if (!ent.lane_wr_n[l]) begin
            rd_word[l*SSWD_LANE_W +: SSWD_LANE_W] = ent.data[l*SSWD_LANE_W +: SSWD_LANE_W];
          end
        end
      end
    end
    if (push_valid && (push_word.addr == acc.addr)) begin
      for (int l = 0; l < SSWD_LANES; l++) begin
        if (!push_word.lane_wr_n[l]) begin
          rd_word[l*SSWD_LANE_W +: SSWD_LANE_W] = push_word.data[l*SSWD_LANE_W +: SSWD_LANE_W];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------

  // Read data appears in the cycle after its address edge.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_r <= SSWD_DATA_RST;
    end else if (enabled && rd_now) begin
      data_r <= rd_word;
    end
  end

  // The bus drives only for a read data phase; a deselect floats it next cycle.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_oe_r <= 1'b0;
    end else if (enabled) begin
      data_oe_r <= rd_now;
    end
  end

  // Room in the write queue, registered for the controller; held on suspended edges.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wq_ready_r <= 1'b0;
    end else if (enabled) begin
      wq_ready_r <= push_ready;
    end
  end

  // Burst activity flag follows the state register.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      burst_r <= 1'b0;
    end else if (enabled) begin
      burst_r <= (state_nxt != SSWD_IDLE);
    end
  end

  assign data_out = data_r;
  assign data_oe_out = data_oe_r;
  assign write_queue_ready_out = wq_ready_r;
  assign burst_active_out = burst_r;

endmodule : sswd_ctl
`default_nettype wire

// *** core/sswd_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Synchronous FIFO with an age-ordered view of every held entry.
// ----------------------------------------------------------------------------
module sswd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [DEPTH*WIDTH-1:0] view_out,
  output logic [DEPTH-1:0] view_valid_out
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] store_r [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_out = (count_r != FULL);
  assign out_valid_out = (count_r != '0);
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = store_r[rd_ptr_r];

  // Pointers and count move on accepted transfers only.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= PW'(wr_ptr_r + 1'b1);
      if (pop) rd_ptr_r <= PW'(rd_ptr_r + 1'b1);
      if (push & ~pop) count_r <= CW'(count_r + 1'b1);
      else if (pop & ~push) count_r <= CW'(count_r - 1'b1);
    end
  end

  // Storage needs no reset; only counted entries are ever read.
  always_ff @(posedge ref_clk_in) begin
    if (push) store_r[wr_ptr_r] <= in_data_in;
  end

  // Entry zero of the view is the oldest held word.
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      view_out[i*WIDTH +: WIDTH] = store_r[PW'(rd_ptr_r + PW'(i))];
      view_valid_out[i] = (CW'(i) < count_r);
    end
  end

endmodule : sswd_fifo
`default_nettype wire

// *** core/sswd_pkg.sv ***
// ----------------------------------------------------------------------------
// Shared constants and carriers for the synchronous SRAM control block.
// ----------------------------------------------------------------------------
package sswd_pkg;

  // Array geometry: 128K words of 36 bits, four byte lanes of 9 bits.
  localparam int SSWD_AW = 17;
  localparam int SSWD_DW = 36;
  localparam int SSWD_LANES = 4;
  localparam int SSWD_LANE_W = 9;
  localparam int SSWD_WORDS = 131072;

  // Burst counter covers the two lowest address bits, four words per burst.
  localparam int SSWD_BURST_W = 2;
  localparam logic [1:0] SSWD_CNT_RST = 2'h0;
  localparam logic [1:0] SSWD_CNT_STEP = 2'h1;

  // Depth of the write queue between data capture and the array.
  localparam int SSWD_WQ_DEPTH = 8;

  // Reset values of the data-side registers.
  localparam logic [35:0] SSWD_DATA_RST = 36'h0_0000_0000;
  localparam logic [16:0] SSWD_ADDR_RST = 17'h0_0000;
  localparam logic [3:0] SSWD_LANES_OFF = 4'hF;

  // Burst direction state; the direction is fixed when a burst is loaded.
  typedef enum logic [1:0] {
    SSWD_IDLE = 2'b00,
    SSWD_READ_BURST = 2'b01,
    SSWD_WRITE_BURST = 2'b10
  } sswd_state_t;

  // One access waiting for its data phase.
  typedef struct packed {
    logic valid;
    logic write;
    logic [16:0] addr;
    logic [3:0] lane_wr_n;
  } sswd_op_t;

  // One captured write on its way into the array.
  typedef struct packed {
    logic [16:0] addr;
    logic [35:0] data;
    logic [3:0] lane_wr_n;
  } sswd_wr_t;

  localparam int SSWD_WR_W = $bits(sswd_wr_t);

endpackage : sswd_pkg

// *** tb/sswd_ctl_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Port checker for the SRAM control block.
// ----------------------------------------------------------------------------
module sswd_ctl_checker (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clock_enable_n_in,
  input wire logic chip_select_low_a_in,
  input wire logic chip_select_low_b_in,
  input wire logic chip_select_high_in,
  input wire logic advance_or_load_in,
  input wire logic read_not_write_in,
  input wire logic [35:0] data_out,
  input wire logic data_oe_out,
  input wire logic write_queue_ready_out,
  input wire logic burst_active_out
);
  logic go;
  logic sel;
  logic rd_go;
  // Decode of a taken edge, full selection and a read load.
  assign go = !clock_enable_n_in;
  assign sel = !chip_select_low_a_in && !chip_select_low_b_in && chip_select_high_in;
  assign rd_go = go && sel && !advance_or_load_in && read_not_write_in;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_susp_hold: assert property (clock_enable_n_in |=> $stable(data_out) && $stable(data_oe_out) && $stable(burst_active_out) && $stable(write_queue_ready_out))
    else $error("suspended edge changed an output");
  a_write_float: assert property (go && sel && !advance_or_load_in && !read_not_write_in |=> !data_oe_out)
    else $error("bus driven after a write load");
  a_read_drive: assert property (rd_go |=> data_oe_out && burst_active_out)
    else $error("read load did not drive the bus");
  a_desel_float: assert property (go && !sel |=> !data_oe_out && !burst_active_out)
    else $error("deselect left the bus driven");
  a_rnw_ignored: assert property (go && sel && advance_or_load_in && burst_active_out && data_oe_out |=> data_oe_out)
    else $error("read burst lost the bus");
  a_wburst_quiet: assert property (go && sel && advance_or_load_in && burst_active_out && !data_oe_out |=> !data_oe_out)
    else $error("write burst drove the bus");
  a_adv_idle: assert property (go && sel && advance_or_load_in && !burst_active_out |=> !data_oe_out)
    else $error("advance without burst drove the bus");
  a_data_held: assert property (go && !rd_go && !(sel && advance_or_load_in && data_oe_out) |=> $stable(data_out))
    else $error("read data changed without a read");
endmodule : sswd_ctl_checker

bind sswd_ctl sswd_ctl_checker i_chk (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .clock_enable_n_in(clock_enable_n_in),
  .chip_select_low_a_in(chip_select_low_a_in),
  .chip_select_low_b_in(chip_select_low_b_in),
  .chip_select_high_in(chip_select_high_in),
  .advance_or_load_in(advance_or_load_in),
  .read_not_write_in(read_not_write_in),
  .data_out(data_out),
  .data_oe_out(data_oe_out),
  .write_queue_ready_out(write_queue_ready_out),
  .burst_active_out(burst_active_out)
);
`default_nettype wire

// *** tb/sswd_ctl_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Memory controller model that drives the SRAM pins.
// ----------------------------------------------------------------------------
module sswd_ctl_model (
  input wire logic ref_clk_in,
  output logic clock_enable_n_out,
  output logic [2:0] select_out,
  output logic advance_or_load_out,
  output logic read_not_write_out,
  output logic burst_order_select_out,
  output logic [16:0] addr_out,
  output logic [3:0] byte_lane_write_n_out,
  output logic [35:0] data_out
);
  // Pins start deselected with the clock suspended.
  initial begin
    clock_enable_n_out = 1'b1;
    select_out = 3'h0;
    advance_or_load_out = 1'b0;
    read_not_write_out = 1'b1;
    burst_order_select_out = 1'b0;
    addr_out = 17'h0_0000;
    byte_lane_write_n_out = 4'hF;
    data_out = 36'h0_0000_0000;
  end

  // One bus cycle: pins change at the falling edge and hold through the rising edge.
  task automatic cyc(input logic cen_n, input logic [2:0] sel, input logic adv, input logic rnw, input logic burst_order_select,
    input logic [16:0] a, input logic [3:0] ln, input logic dv, input logic [35:0] d);
    @(negedge ref_clk_in);
    clock_enable_n_out = cen_n;
    select_out = sel;
    advance_or_load_out = adv;
    read_not_write_out = rnw;
    burst_order_select_out = burst_order_select;
    addr_out = a;
    byte_lane_write_n_out = ln;
    // With no data due, the bus shows the inverse of its last word, never a stale copy.
    data_out = dv ? d : ~data_out;
    @(posedge ref_clk_in);
    #5;
  endtask : cyc
endmodule : sswd_ctl_model
`default_nettype wire

// *** tb/sswd_ctl_test.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Self-checking bench for the SRAM control block.
// ----------------------------------------------------------------------------
module sswd_ctl_test;
  import sswd_pkg::*;
  localparam logic [2:0] ON = 3'h4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cen_n, adv, rnw, burst_order_select, oe, wq_rdy, bact;
  logic [2:0] sel;
  // Burst order wanted by the tests; the model alone drives the order pin.
  logic ord = 1'b0;
  logic [16:0] addr, e;
  logic [3:0] ln;
  logic [35:0] din, dout;
  logic [35:0] ref_mem [logic [16:0]];
  int fails = 0;
  int checks_done = 0;

  // Free-running 20 MHz clock.
  always #25 ref_clk = ~ref_clk;

  sswd_ctl_model i_ctl (.ref_clk_in(ref_clk), .clock_enable_n_out(cen_n), .select_out(sel),
    .advance_or_load_out(adv), .read_not_write_out(rnw), .burst_order_select_out(burst_order_select), .addr_out(addr),
    .byte_lane_write_n_out(ln), .data_out(din));
  sswd_ctl i_dut (.ref_clk_in(ref_clk), .rst_in(rst), .clock_enable_n_in(cen_n), .chip_select_low_a_in(sel[0]),
    .chip_select_low_b_in(sel[1]), .chip_select_high_in(sel[2]), .advance_or_load_in(adv),
    .read_not_write_in(rnw), .burst_order_select_in(burst_order_select), .addr_in(addr), .byte_lane_write_n_in(ln),
    .data_in(din), .data_out(dout), .data_oe_out(oe), .write_queue_ready_out(wq_rdy),
    .burst_active_out(bact));

  // Comparisons of words and of single flags.
  task automatic chk_word(input string nm, input logic [35:0] x, input logic [35:0] g);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string nm, input logic x, input logic g);
    chk_word(nm, {35'h0, x}, {35'h0, g});
  endtask : chk_bit

  // Load and advance cycles; advance drives read-not-write low to show it is ignored.
  task automatic ld(input logic rd, input logic [16:0] a, input logic [3:0] l, input logic dv, input logic [35:0] d);
    i_ctl.cyc(1'b0, ON, 1'b0, rd, ord, a, l, dv, d);
  endtask : ld
  task automatic ad(input logic dv, input logic [35:0] d);
    i_ctl.cyc(1'b0, ON, 1'b1, 1'b0, ord, 17'h0_0000, 4'h0, dv, d);
  endtask : ad

  // Expected memory: merges the enabled lanes of a write.
  function automatic void upd(input logic [16:0] a, input logic [3:0] l, input logic [35:0] d);
    logic [35:0] m;
    m = ref_mem.exists(a) ? ref_mem[a] : 36'h0_0000_0000;
    for (int i = 0; i < SSWD_LANES; i++) begin
      if (!l[i]) m[i*SSWD_LANE_W +: SSWD_LANE_W] = d[i*SSWD_LANE_W +: SSWD_LANE_W];
    end
    ref_mem[a] = m;
  endfunction : upd

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // Watchdog well beyond the few dozen cycles the tests need.
  initial begin
    #200000;
    fails++;
    give_verdict();
  end

  // Main sequence of tests.
  initial begin
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    i_ctl.cyc(1'b0, 3'h0, 1'b1, 1'b1, 1'b0, 17'h0_0000, 4'hF, 1'b0, 36'h0);
    chk_bit("queue ready", 1'b1, wq_rdy);
    ld(1'b0, 17'h0_0010, 4'h0, 1'b0, 36'h0);
    chk_bit("write oe", 1'b0, oe);
    for (int n = 0; n < 3; n++) begin
      ad(1'b1, 36'h1_2345_6780 + n);
      upd(17'h0_0010 + 17'(n), 4'h0, 36'h1_2345_6780 + n);
      chk_bit("write burst", 1'b1, bact);
    end
    i_ctl.cyc(1'b0, 3'h5, 1'b0, 1'b1, ord, 17'h0_0000, 4'h0, 1'b1, 36'hA_BCDE_F013);
    upd(17'h0_0013, 4'h0, 36'hA_BCDE_F013);
    ld(1'b0, 17'h0_0020, 4'h0, 1'b0, 36'h0);
    ld(1'b0, 17'h0_0020, 4'hA, 1'b1, 36'h3_3333_3333);
    upd(17'h0_0020, 4'h0, 36'h3_3333_3333);
    i_ctl.cyc(1'b0, 3'h0, 1'b0, 1'b1, ord, 17'h0_0000, 4'hF, 1'b1, 36'hC_CCCC_CCCC);
    upd(17'h0_0020, 4'hA, 36'hC_CCCC_CCCC);
    $display("test writes done");
    for (int o = 0; o < 2; o++) begin
      ord = o[0];
      ld(1'b1, 17'h0_0011, 4'hF, 1'b0, 36'h0);
      for (int n = 0; n < 4; n++) begin
        if (n > 0) ad(1'b0, 36'h0);
        e = ord ? (17'h0_0011 ^ 17'(n)) : {15'h0004, 2'(n + 1)};
        chk_word("read burst data", ref_mem[e], dout);
        chk_bit("read oe", 1'b1, oe);
      end
    end
    ord = 1'b0;
    ld(1'b1, 17'h0_0020, 4'hF, 1'b0, 36'h0);
    chk_word("lane merge", ref_mem[17'h0_0020], dout);
    $display("test bursts done");
    ld(1'b1, 17'h0_0012, 4'hF, 1'b0, 36'h0);
    i_ctl.cyc(1'b1, 3'h0, 1'b0, 1'b0, 1'b1, 17'h1_FFFF, 4'h0, 1'b0, 36'h0);
    chk_word("suspended data", ref_mem[17'h0_0012], dout);
    chk_bit("suspended oe", 1'b1, oe);
    ad(1'b0, 36'h0);
    chk_word("resumed burst", ref_mem[17'h0_0013], dout);
    $display("test suspend done");
    for (int k = 0; k < 3; k++) begin
      ld(1'b1, 17'h0_0010, 4'hF, 1'b0, 36'h0);
      chk_word("pending read", ref_mem[17'h0_0010], dout);
      i_ctl.cyc(1'b0, ON ^ 3'(3'h1 << k), 1'b0, 1'b1, ord, 17'h0_0011, 4'hF, 1'b0, 36'h0);
      chk_bit("deselect oe", 1'b0, oe);
      chk_bit("deselect burst", 1'b0, bact);
      ad(1'b0, 36'h0);
      chk_bit("idle advance oe", 1'b0, oe);
    end
    $display("test deselect done");
    give_verdict();
  end
endmodule : sswd_ctl_test
`default_nettype wire
